// file: core/sccc_pkg.sv
// Constants and state types shared by the serial configuration chain controller
// Notes on behaviour
// - Own share taken: assert chain enable, release done.
// - Later devices hold done low until filled.
// - Done line high: whole chain starts initialization.
// - Configuration error pulls shared status line low.
// - Auto restart: reconfigure within 500 us time-out.
// - Auto restart: status low pulse 10..500 us.
// - Identical slaves get same data and clock.
// - Oscillator at 40 MHz, flash link at half that, one bit per cycle.
// - Request held low keeps device in reset.
// - Own share captured: drive chain enable low.
// - Launch on falling edges, latch data on falling.
package sccc_pkg;

  // ---------------------------------------------------------------------------
  // Clock rates and times
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned LINK_FREQ_MHZ     = 40;        // Nominal oscillator rate
  localparam int unsigned LINK_PERIOD_NS    = 25;        // Oscillator period; one bit takes two of these
  localparam int unsigned STATUS_LOW_MIN_NS = 10_000;
  localparam int unsigned STATUS_LOW_MAX_NS = 500_000;
  // Least time rounds up; 2500 cycles sits well inside the 500 us ceiling
  localparam int unsigned STATUS_LOW_CYC    =
    (STATUS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_CYCLES_DEF   = 8532;
  localparam int unsigned SHARE_BYTES_DEF   = 1024;

  // ---------------------------------------------------------------------------
  // Flash link framing
  // ---------------------------------------------------------------------------
  localparam int unsigned CMD_W      = 8;
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned FRAME_W    = CMD_W + ADDR_W;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned TIMER_W    = 32;
  localparam int unsigned BIT_CNT_W  = 6;
  localparam logic [CMD_W-1:0]  FLASH_READ_CMD   = 8'h03;
  localparam logic [ADDR_W-1:0] FLASH_START_ADDR = 24'h00_0000;
  localparam logic [1:0]        TURN_FALLS       = 2'h2;  // Idle falls before first data

  // ---------------------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SCCC_RESET,
    SCCC_CONFIG,
    SCCC_WAIT_DONE,
    SCCC_INIT,
    SCCC_USER,
    SCCC_ERR_PULSE,
    SCCC_ERR_HOLD,
    SCCC_STATUS_WAIT
  } sccc_sys_state_t;

  typedef enum logic [1:0] {
    SCCC_L_IDLE,
    SCCC_L_CMD,
    SCCC_L_TURN,
    SCCC_L_READ
  } sccc_link_state_t;

endpackage : sccc_pkg

// file: core/sccc_buf.sv
// Small flip-flop buffer with valid and ready on both sides
`timescale 1ns/100ps
module sccc_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  // Filling side
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  // Draining side
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  import sccc_pkg::*;

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
  logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
  logic [PTR_W:0]   count,  next_count;
  logic             push, pop;

  // -------------------------------------------------------------------------
  // Handshake
  // -------------------------------------------------------------------------
  assign wr_ready_o = (count != (PTR_W+1)'(DEPTH));
  assign rd_valid_o = (count != '0);
  assign rd_data_o  = mem[rd_ptr];
  assign push       = wr_valid_i && wr_ready_o;
  assign pop        = rd_valid_o && rd_ready_i;

  // Pointer and count update; flush drops whatever is held
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    next_mem    = mem;
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (push) begin
        next_mem[wr_ptr] = wr_data_i;
        next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        next_count = count + 1'b1;
      end else if (pop && !push) begin
        next_count = count - 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      for (int i = 0; i < int'(DEPTH); i++) begin
        mem[i] <= '0;
      end
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      mem    <= next_mem;
    end
  end

endmodule : sccc_buf

// file: core/sccc_top.sv
// Chain master: flash reader, chain done and status lines, restart and start-up
`timescale 1ns/100ps
module sccc_top
  import sccc_pkg::*;
#(
  parameter int unsigned SHARE_BYTES = sccc_pkg::SHARE_BYTES_DEF,
  parameter int unsigned INIT_CYCLES = sccc_pkg::INIT_CYCLES_DEF,
  parameter int unsigned BUF_DEPTH   = 2
) (
  // System clock; reset is the active-low configuration request
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Internal oscillator that paces the flash link
  input  wire logic               link_clk_i,
  // Option and chain inputs (pins)
  input  wire logic               auto_restart_i,
  input  wire logic               chip_enable_in_n_i,
  // Error report from the configuration core
  input  wire logic               frame_error_i,
  // Flash link pins
  output logic                    serial_config_clock_o,
  output logic                    flash_select_out_n_o,
  output logic                    flash_command_out_o,
  output logic                    link_oe_o,
  input  wire logic               flash_data_i,
  // Parallel feed to slaves
  output logic                    slave_clock_o,
  output logic                    slave_data_o,
  // Shared open-drain done line
  input  wire logic               config_complete_line_i,
  output logic                    config_complete_line_o,
  output logic                    config_complete_line_oe_o,
  // Shared open-drain status line
  input  wire logic               status_line_i,
  output logic                    status_line_o,
  output logic                    status_line_oe_o,
  // Chain enable to next device
  output logic                    chain_enable_out_n_o,
  // Configuration byte stream to the core
  output logic [sccc_pkg::BYTE_W-1:0] cfg_data_o,
  output logic                    cfg_valid_o,
  input  wire logic               cfg_ready_i,
  // Phase indications
  output logic                    init_phase_o,
  output logic                    user_mode_o
);
  import sccc_pkg::*;

  // ---------------------------------------------------------------------------
  // System domain: input synchronisers
  // ---------------------------------------------------------------------------
  logic [4:0] sys_s1, sys_s2;
  logic       auto_restart, ce_n, done_high, status_high, req_seen, link_busy;

  // Pins and link-domain levels pass two flops before any logic sees them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_s1 <= 5'h00;
      sys_s2 <= 5'h00;
    end else begin
      sys_s1 <= {auto_restart_i, chip_enable_in_n_i, config_complete_line_i,
                 status_line_i, req_tgl};
      sys_s2 <= sys_s1;
    end
  end

  logic ack_tgl, req_tgl, link_busy_l;
  logic link_busy_s1, link_busy_s2;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_busy_s1 <= 1'b0;
      link_busy_s2 <= 1'b0;
    end else begin
      link_busy_s1 <= link_busy_l;
      link_busy_s2 <= link_busy_s1;
    end
  end

  assign {auto_restart, ce_n, done_high, status_high, req_seen} = sys_s2;
  assign link_busy = link_busy_s2;

  // ---------------------------------------------------------------------------
  // System domain: byte handover and buffer
  // ---------------------------------------------------------------------------
  logic              byte_pending, buf_wr_valid, buf_wr_ready, buf_rd_valid, buf_rd_ready;
  logic              flush, running, own_done, take;
  logic [BYTE_W-1:0] hold_l;

  // Word crosses by toggle handshake: hold_l is stable while a toggle is open
  assign byte_pending = (req_seen != ack_tgl);
  assign buf_wr_valid = byte_pending && running;
  assign buf_rd_ready = own_done ? 1'b1 : cfg_ready_i;  // Slaves' bytes are drained
  assign cfg_valid_o  = buf_rd_valid && !own_done;
  assign take         = cfg_valid_o && cfg_ready_i;

  sccc_buf #(
    .WIDTH (BYTE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .flush_i    (flush),
    .wr_data_i  (hold_l),
    .wr_valid_i (buf_wr_valid),
    .wr_ready_o (buf_wr_ready),
    .rd_data_o  (cfg_data_o),
    .rd_valid_o (buf_rd_valid),
    .rd_ready_i (buf_rd_ready)
  );

  // ---------------------------------------------------------------------------
  // System domain: configuration sequence
  // ---------------------------------------------------------------------------
  sccc_sys_state_t    state, next_state;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [31:0]        byte_cnt, next_byte_cnt;
  logic               next_own_done, next_ack_tgl, link_run, next_link_run;
  logic               status_drive, next_status_drive, done_drive, next_done_drive;
  logic               init_phase, next_init_phase, user_mode, next_user_mode;

  assign running = (state == SCCC_CONFIG) || (state == SCCC_WAIT_DONE);
  assign flush   = (state == SCCC_RESET);

  always_comb begin
    next_state        = state;
    next_timer        = timer;
    next_byte_cnt     = byte_cnt;
    next_own_done     = own_done;
    next_ack_tgl      = ack_tgl;
    next_link_run     = link_run;
    next_init_phase   = 1'b0;
    next_user_mode    = 1'b0;
    // Bytes offered outside a run are acknowledged and dropped
    if (byte_pending && (!running || buf_wr_ready)) begin
      next_ack_tgl = ~ack_tgl;
    end
    unique case (state)
      SCCC_RESET: begin
        next_timer    = '0;
        next_byte_cnt = '0;
        next_own_done = 1'b0;
        next_link_run = 1'b0;
        // Chip enable high means a programmer owns the flash
        if (!ce_n && !link_busy && status_high && !byte_pending) begin
          next_state    = SCCC_CONFIG;
          next_link_run = 1'b1;
        end
      end
      SCCC_CONFIG, SCCC_WAIT_DONE: begin
        if (take) begin
          next_byte_cnt = byte_cnt + 32'h0000_0001;
          if (byte_cnt == 32'(SHARE_BYTES - 1)) begin
            next_own_done = 1'b1;
            next_state    = SCCC_WAIT_DONE;
          end
        end
        if (frame_error_i) begin
          next_link_run = 1'b0;
          next_timer    = '0;
          next_state    = auto_restart ? SCCC_ERR_PULSE : SCCC_ERR_HOLD;
        end else if (!status_high) begin
          // Another device failed; stop feeding and wait for its release
          next_link_run = 1'b0;
          next_state    = SCCC_STATUS_WAIT;
        end else if (state == SCCC_WAIT_DONE && own_done && done_high) begin
          next_link_run   = 1'b0;
          next_timer      = '0;
          next_init_phase = 1'b1;
          next_state      = SCCC_INIT;
        end
      end
      SCCC_INIT: begin
        next_init_phase = 1'b1;
        next_timer      = timer + 1'b1;
        if (timer == TIMER_W'(INIT_CYCLES - 1)) begin
          next_init_phase = 1'b0;
          next_user_mode  = 1'b1;
          next_state      = SCCC_USER;
        end
      end
      SCCC_USER: begin
        next_user_mode = 1'b1;
      end
      SCCC_ERR_PULSE: begin
        // Single low pulse, then the chain restarts at once
        next_timer = timer + 1'b1;
        if (timer == TIMER_W'(STATUS_LOW_CYC - 1)) begin
          next_state = SCCC_RESET;
        end
      end
      SCCC_ERR_HOLD: begin
        // Only a configuration request pulse clears this
        next_state = SCCC_ERR_HOLD;
      end
      SCCC_STATUS_WAIT: begin
        if (status_high && auto_restart) begin
          next_state = SCCC_RESET;
        end
      end
    endcase
    // Line drives follow the state being entered
    next_status_drive = (next_state == SCCC_ERR_PULSE) ||
                        (next_state == SCCC_ERR_HOLD);
    next_done_drive   = !next_own_done &&
                        (next_state != SCCC_INIT) && (next_state != SCCC_USER);
  end

  // Status is held low from the request until the first edge after release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state        <= SCCC_RESET;
      timer        <= '0;
      byte_cnt     <= 32'h0000_0000;
      own_done     <= 1'b0;
      ack_tgl      <= 1'b0;
      link_run     <= 1'b0;
      status_drive <= 1'b1;
      done_drive   <= 1'b1;
      init_phase   <= 1'b0;
      user_mode    <= 1'b0;
    end else begin
      state        <= next_state;
      timer        <= next_timer;
      byte_cnt     <= next_byte_cnt;
      own_done     <= next_own_done;
      ack_tgl      <= next_ack_tgl;
      link_run     <= next_link_run;
      status_drive <= next_status_drive;
      done_drive   <= next_done_drive;
      init_phase   <= next_init_phase;
      user_mode    <= next_user_mode;
    end
  end

  // Open-drain lines only ever pull low
  assign status_line_o             = 1'b0;
  assign status_line_oe_o          = status_drive;
  assign config_complete_line_o    = 1'b0;
  assign config_complete_line_oe_o = done_drive;
  assign chain_enable_out_n_o      = !own_done;
  assign init_phase_o              = init_phase;
  assign user_mode_o               = user_mode;

  // ---------------------------------------------------------------------------
  // Link domain: synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] lnk_s1, lnk_s2;
  logic       run_l, ack_l, data_l, stall;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lnk_s1 <= 3'h0;
      lnk_s2 <= 3'h0;
    end else begin
      lnk_s1 <= {link_run, ack_tgl, flash_data_i};
      lnk_s2 <= stall ? {lnk_s1[2:1], lnk_s2[0]} : lnk_s1;  // Pin already shows the next bit
    end
  end

  assign {run_l, ack_l, data_l} = lnk_s2;

  // ---------------------------------------------------------------------------
  // Link domain: flash reader
  // ---------------------------------------------------------------------------
  sccc_link_state_t     lstate, next_lstate;
  logic                 serial_config_clock, next_serial_config_clock, sel_n, next_sel_n, cmd, next_cmd;
  logic                 oe, next_oe, next_req_tgl, sdata, next_sdata;
  logic                 next_link_busy_l;
  logic [FRAME_W-1:0]   frame, next_frame;
  logic [BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [1:0]           turn, next_turn;
  logic [BYTE_W-1:0]    shreg, next_shreg, next_hold_l;
  logic [2:0]           nbits, next_nbits;

  // Holding the clock high when a byte cannot be handed over stops the flash too
  assign stall = (lstate == SCCC_L_READ) && (nbits == 3'h7) && (req_tgl != ack_l);

  always_comb begin
    next_lstate  = lstate;
    next_serial_config_clock    = serial_config_clock;
    next_sel_n   = sel_n;
    next_cmd     = cmd;
    next_oe      = oe;
    next_req_tgl = req_tgl;
    next_sdata   = sdata;
    next_frame   = frame;
    next_bit_cnt = bit_cnt;
    next_turn    = turn;
    next_shreg   = shreg;
    next_hold_l  = hold_l;
    next_nbits   = nbits;
    if (!run_l) begin
      // Stop: deselect and release every link pin
      next_lstate = SCCC_L_IDLE;
      next_serial_config_clock   = 1'b1;
      next_sel_n  = 1'b1;
      next_oe     = 1'b0;
    end else if (lstate == SCCC_L_IDLE) begin
      next_lstate  = SCCC_L_CMD;
      next_oe      = 1'b1;
      next_sel_n   = 1'b0;
      next_serial_config_clock    = 1'b1;
      next_frame   = {FLASH_READ_CMD, FLASH_START_ADDR};
      next_bit_cnt = '0;
      next_turn    = '0;
      next_nbits   = '0;
    end else if (!serial_config_clock) begin
      next_serial_config_clock = 1'b1;
    end else if (!stall) begin
      // Falling edge: every launch and latch happens here
      next_serial_config_clock = 1'b0;
      unique case (lstate)
        SCCC_L_CMD: begin
          next_cmd     = frame[FRAME_W-1];
          next_frame   = {frame[FRAME_W-2:0], 1'b0};
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == BIT_CNT_W'(FRAME_W - 1)) begin
            next_lstate = SCCC_L_TURN;
          end
        end
        SCCC_L_TURN: begin
          next_turn = turn + 1'b1;
          if (turn == TURN_FALLS - 2'h1) begin
            next_lstate = SCCC_L_READ;
          end
        end
        SCCC_L_READ: begin
          next_sdata = data_l;
          next_shreg = {data_l, shreg[BYTE_W-1:1]};
          next_nbits = nbits + 1'b1;
          if (nbits == 3'h7) begin
            next_hold_l  = {data_l, shreg[BYTE_W-1:1]};
            next_req_tgl = ~req_tgl;
          end
        end
        default: begin
          next_lstate = SCCC_L_IDLE;
        end
      endcase
    end
    next_link_busy_l = (next_lstate != SCCC_L_IDLE);
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lstate      <= SCCC_L_IDLE;
      serial_config_clock        <= 1'b1;
      sel_n       <= 1'b1;
      cmd         <= 1'b1;
      oe          <= 1'b0;
      req_tgl     <= 1'b0;
      sdata       <= 1'b0;
      frame       <= '0;
      bit_cnt     <= '0;
      turn        <= '0;
      shreg       <= '0;
      hold_l      <= '0;
      nbits       <= '0;
      link_busy_l <= 1'b0;
    end else begin
      lstate      <= next_lstate;
      serial_config_clock        <= next_serial_config_clock;
      sel_n       <= next_sel_n;
      cmd         <= next_cmd;
      oe          <= next_oe;
      req_tgl     <= next_req_tgl;
      sdata       <= next_sdata;
      frame       <= next_frame;
      bit_cnt     <= next_bit_cnt;
      turn        <= next_turn;
      shreg       <= next_shreg;
      hold_l      <= next_hold_l;
      nbits       <= next_nbits;
      link_busy_l <= next_link_busy_l;
    end
  end

  // Same clock reaches the flash and every slave; slaves also get each bit read from the flash
  assign serial_config_clock_o = serial_config_clock;
  assign flash_select_out_n_o  = sel_n;
  assign flash_command_out_o   = cmd;
  assign link_oe_o             = oe;
  assign slave_clock_o         = serial_config_clock;
  assign slave_data_o          = sdata;

endmodule : sccc_top

// file: tb/sccc_flash_model.sv
// Serial flash model: takes a command frame, returns a byte pattern
`timescale 1ns/100ps
module sccc_flash_model (
  // Link pins as seen at the flash
  input  wire logic   sclk_i,
  input  wire logic   sel_n_i,
  input  wire logic   cmd_i,
  // Data back to the device
  output logic        data_o,
  output logic [31:0] cmd_word_o
);
  int         rises = 0;
  int         falls = 0;
  int         b;
  logic [7:0] v;
  initial data_o = 1'b1;
  // Select change restarts the frame; released data floats to its pull-up
  always @(sel_n_i) begin
    rises = 0;
    falls = 0;
    data_o = 1'b1;
  end
  // Command and address taken on rising edges
  always @(posedge sclk_i) begin
    if (!sel_n_i && rises < 32) begin
      cmd_word_o = {cmd_word_o[30:0], cmd_i};
      rises++;
    end
  end
  // One data bit per falling edge after the frame, byte LSB first
  always @(negedge sclk_i) begin
    if (!sel_n_i) begin
      falls++;
      b = falls - 33;
      v = 8'h3C ^ 8'((b / 8) * 17);
      if (falls >= 33) data_o = v[b%8];
    end
  end
endmodule : sccc_flash_model

// file: tb/sccc_top_props.sv
// Port checker for the chain controller
`timescale 1ns/100ps
module sccc_top_props
  import sccc_pkg::*;
(
  // Clock, reset and pins watched
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic auto_restart_i,
  input wire logic chip_enable_in_n_i,
  input wire logic frame_error_i,
  input wire logic serial_config_clock_o,
  input wire logic flash_select_out_n_o,
  input wire logic flash_command_out_o,
  input wire logic link_oe_o,
  input wire logic slave_clock_o,
  input wire logic config_complete_line_i,
  input wire logic config_complete_line_oe_o,
  input wire logic status_line_oe_o,
  input wire logic chain_enable_out_n_o,
  input wire logic init_phase_o
);
  logic [15:0] low_cnt;
  // Length of the current status pull, too long for a repetition
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= status_line_oe_o ? low_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chain_rel_a: assert property ($fell(chain_enable_out_n_o) |-> !config_complete_line_oe_o)
    else $error("done still held after chain enable");
  done_hold_a: assert property (chain_enable_out_n_o |-> config_complete_line_oe_o)
    else $error("done released before share");
  init_sync_a: assert property ($rose(init_phase_o) |->
    $past(config_complete_line_i) && $past(config_complete_line_i, 2))
    else $error("init started with done line low");
  err_pull_a: assert property (frame_error_i && link_oe_o |=> status_line_oe_o)
    else $error("error did not pull status");
  pulse_len_a: assert property ($fell(status_line_oe_o) && low_cnt > 16'h0008 |->
    low_cnt == 16'(STATUS_LOW_CYC))
    else $error("status pulse length wrong");
  restart_a: assert property ($fell(status_line_oe_o) && low_cnt > 16'h0008 && auto_restart_i
    |-> ##[1:600] !flash_select_out_n_o)
    else $error("no restart after status pulse");
  ce_block_a: assert property (chip_enable_in_n_i [*8] |-> !link_oe_o)
    else $error("link driven while chip disabled");
  slave_clk_a: assert property (slave_clock_o == serial_config_clock_o)
    else $error("slave clock differs");
  rate_hi_a: assert property ($rose(serial_config_clock_o) |=> serial_config_clock_o [*8])
    else $error("serial clock high phase short");
  cmd_edge_a: assert property ($changed(flash_command_out_o) && !flash_select_out_n_o
    |-> !serial_config_clock_o)
    else $error("command changed off falling edge");
endmodule : sccc_top_props
bind sccc_top sccc_top_props i_sccc_top_props (.clk_i, .rst_n_i, .auto_restart_i,
  .chip_enable_in_n_i, .frame_error_i, .serial_config_clock_o, .flash_select_out_n_o,
  .flash_command_out_o, .link_oe_o, .slave_clock_o, .config_complete_line_i,
  .config_complete_line_oe_o, .status_line_oe_o, .chain_enable_out_n_o, .init_phase_o);

// file: tb/test_sccc_top.sv
// Self-checking bench for the chain controller
`timescale 1ns/100ps
module test_sccc_top;
  import sccc_pkg::*;
  logic       clk_i = 1'b0, link_clk_i = 1'b0, rst_n_i = 1'b0, auto_restart_i = 1'b0;
  logic       chip_enable_in_n_i = 1'b0, frame_error_i = 1'b0, cfg_ready_i = 1'b0;
  logic       other_done = 1'b1, flash_data_i, serial_config_clock_o, flash_select_out_n_o;
  logic       flash_command_out_o, link_oe_o, config_complete_line_oe_o, status_line_oe_o;
  logic       chain_enable_out_n_o, cfg_valid_o, init_phase_o, user_mode_o;
  logic [7:0] cfg_data_o;
  logic [31:0] cmd_word;
  int         compares = 0, n_mismatch = 0, n;
  // Open-drain lines with pull-ups; released link pins float high
  wire config_complete_line_i = !(config_complete_line_oe_o || other_done);
  wire status_line_i = !status_line_oe_o;
  wire fl_clk = link_oe_o ? serial_config_clock_o : 1'b1;
  wire fl_sel = link_oe_o ? flash_select_out_n_o : 1'b1;
  // Oscillator offset so its edges never meet the system clock
  initial forever #2 clk_i = ~clk_i;
  initial begin
    #1.3;
    forever #24 link_clk_i = ~link_clk_i;
  end
  sccc_top #(.SHARE_BYTES(4), .INIT_CYCLES(16)) i_sccc_top (.clk_i, .rst_n_i, .link_clk_i,
    .auto_restart_i, .chip_enable_in_n_i, .frame_error_i, .serial_config_clock_o,
    .flash_select_out_n_o, .flash_command_out_o, .link_oe_o, .flash_data_i,
    .slave_clock_o(), .slave_data_o(), .config_complete_line_i,
    .config_complete_line_o(), .config_complete_line_oe_o, .status_line_i,
    .status_line_o(), .status_line_oe_o, .chain_enable_out_n_o, .cfg_data_o,
    .cfg_valid_o, .cfg_ready_i, .init_phase_o, .user_mode_o);
  sccc_flash_model i_sccc_flash_model (.sclk_i(fl_clk), .sel_n_i(fl_sel),
    .cmd_i(flash_command_out_o), .data_o(flash_data_i), .cmd_word_o(cmd_word));
  // -------------------------------------------------------------------------
  // Compare and sequencing helpers
  // -------------------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: bit %b not %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: byte %h not %h", $time, got, exp);
    end
  endtask : chk_byte
  // Request pin low for hold cycles, options set meanwhile
  task automatic reset_chain(input logic ce, input logic ar, input int hold);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    chip_enable_in_n_i <= ce;
    auto_restart_i <= ar;
    repeat (hold) @(posedge clk_i);
    chk_bit(link_oe_o, 1'b0);
    rst_n_i <= 1'b1;
  endtask : reset_chain
  task automatic wait_select;
    for (n = 0; n < 800 && flash_select_out_n_o !== 1'b0; n++) @(negedge clk_i);
  endtask : wait_select
  task automatic pulse_error;
    repeat (300) @(posedge clk_i);
    frame_error_i <= 1'b1;
    @(posedge clk_i);
    frame_error_i <= 1'b0;
    @(negedge clk_i);
    chk_bit(status_line_i, 1'b0);
  endtask : pulse_error
  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_stream;
    reset_chain(1'b0, 1'b0, 3);
    repeat (2000) @(posedge clk_i);
    chk_bit(serial_config_clock_o, 1'b1);
    chk_byte(cmd_word[31:24], FLASH_READ_CMD);
    cfg_ready_i <= 1'b1;
    @(negedge clk_i);
    for (int i = 0; i < 4; i++) begin
      for (n = 0; n < 900 && cfg_valid_o !== 1'b1; n++) @(negedge clk_i);
      chk_byte(cfg_data_o, 8'h3C ^ 8'(i * 17));
      @(negedge clk_i);
    end
    repeat (40) @(negedge clk_i);
    chk_bit(chain_enable_out_n_o, 1'b0);
    chk_bit(config_complete_line_oe_o, 1'b0);
    chk_bit(init_phase_o, 1'b0);
    chk_bit(cfg_valid_o, 1'b0);
    @(posedge clk_i);
    other_done <= 1'b0;
    for (n = 0; n < 20 && init_phase_o !== 1'b1; n++) @(negedge clk_i);
    chk_bit(init_phase_o, 1'b1);
    repeat (30) @(negedge clk_i);
    chk_bit(user_mode_o, 1'b1);
    $display("test stream done");
  endtask : t_stream
  task automatic t_err_auto;
    reset_chain(1'b0, 1'b1, 3);
    pulse_error;
    repeat (2490) @(negedge clk_i);
    chk_bit(status_line_oe_o, 1'b1);
    repeat (20) @(negedge clk_i);
    chk_bit(status_line_oe_o, 1'b0);
    wait_select;
    chk_bit(flash_select_out_n_o, 1'b0);
    $display("test auto restart done");
  endtask : t_err_auto
  task automatic t_err_manual;
    reset_chain(1'b0, 1'b0, 3);
    pulse_error;
    repeat (3000) @(negedge clk_i);
    chk_bit(status_line_oe_o, 1'b1);
    reset_chain(1'b0, 1'b0, 500);
    wait_select;
    chk_bit(flash_select_out_n_o, 1'b0);
    $display("test manual restart done");
  endtask : t_err_manual
  task automatic t_chip_off;
    reset_chain(1'b1, 1'b0, 3);
    repeat (1000) @(negedge clk_i);
    chk_bit(link_oe_o, 1'b0);
    reset_chain(1'b0, 1'b0, 3);
    wait_select;
    chk_bit(link_oe_o, 1'b1);
    $display("test chip disabled done");
  endtask : t_chip_off
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Main sequence after the opening reset
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_stream;
    t_err_auto;
    t_err_manual;
    t_chip_off;
    test_done;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    test_done;
  end
endmodule : test_sccc_top
